// ===== trim_swap_defines.vh
// Register indices, field layouts, reset values and timing constants
`ifndef TRIM_SWAP_DEFINES_VH
`define TRIM_SWAP_DEFINES_VH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define IDX_BANDGAP 10'h07c
`define IDX_TERM_A 10'h07e
`define IDX_TERM_B 10'h07f
`define IDX_TERM_C 10'h080
`define IDX_TERM_D 10'h081
`define IDX_OVERLAP 10'h09a
`define IDX_STEER 10'h09b
`define IDX_SWAP_CTRL 10'h0a0
`define IDX_SWAP_STATUS 10'h0a1
`define IDX_SWAP_COUNT 10'h0a2

// ****************************************
// Field layouts
// ****************************************
`define BANDGAP_W 4
`define TERM_W 8
`define DELAY_W 5
`define OVERLAP_LEN_W 7
`define CTRL_CAL_EN_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_DUAL_BIT 1
`define STAT_SELECT_BIT 2

// ****************************************
// Reset values
// ****************************************
`define BANDGAP_RESET 4'h0
`define TERM_RESET 8'h00
`define OVERLAP_RESET 5'h08
`define STEER_RESET 5'h07

// ****************************************
// Timing: overlap = base + 2 x setting, in converter clocks
// ****************************************
`define OVERLAP_BASE 7'h04

`endif

// ===== swap_timer.v
// Timing of one background converter swap
`include "trim_swap_defines.vh"

module swap_timer #(
	parameter DW = `DELAY_W,
	parameter LW = `OVERLAP_LEN_W
) (
	input wire clk,
	input wire resetn,
	input wire start,
	input wire [DW-1:0] overlap_set,
	input wire [DW-1:0] steer_delay_set,
	output reg busy,
	output reg dual_sample,
	output reg steer_select,
	output reg done
);

	localparam S_IDLE = 1'b0;
	localparam S_SWAP = 1'b1;

	reg state_reg;
	reg [LW-1:0] len_reg;
	reg [DW-1:0] delay_reg;
	reg [LW-1:0] cnt_reg;
	reg flipped_reg;
	wire [LW-1:0] len_next;
	wire window_end;
	wire flip_now;

	// ****************************************
	// Window length from the latched setting
	// ****************************************
	assign len_next = `OVERLAP_BASE + {overlap_set, 1'b0};
	assign window_end = dual_sample && (cnt_reg == len_reg - 7'h01);
	assign flip_now = !flipped_reg && (cnt_reg == {2'b00, delay_reg});

	// ****************************************
	// Swap sequencer
	// ****************************************
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= S_IDLE;
			len_reg <= {LW{1'b0}};
			delay_reg <= {DW{1'b0}};
			cnt_reg <= {LW{1'b0}};
			flipped_reg <= 1'b0;
			busy <= 1'b0;
			dual_sample <= 1'b0;
			steer_select <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (start) begin
						// Settings sampled only at swap start
						len_reg <= len_next;
						delay_reg <= steer_delay_set;
						cnt_reg <= {LW{1'b0}};
						flipped_reg <= 1'b0;
						busy <= 1'b1;
						dual_sample <= 1'b1;
						state_reg <= S_SWAP;
					end
				end
				S_SWAP: begin
					cnt_reg <= cnt_reg + 7'h01;
					if (window_end) begin
						dual_sample <= 1'b0;
					end
					if (flip_now) begin
						// Select flips a set delay after start
						steer_select <= !steer_select;
						flipped_reg <= 1'b1;
					end
					if ((flipped_reg || flip_now) &&
						(!dual_sample || window_end)) begin
						busy <= 1'b0;
						done <= 1'b1;
						state_reg <= S_IDLE;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

endmodule

// ===== trim_and_swap_delay_regs.v
// Trim and swap delay register bank with Avalon-MM slave
`include "trim_swap_defines.vh"

module trim_and_swap_delay_regs #(
	parameter AW = 12,
	parameter BW = `BANDGAP_W,
	parameter TW = `TERM_W,
	parameter DW = `DELAY_W
) (
	input wire clk,
	input wire resetn,
	input wire [AW-1:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output wire waitrequest,
	input wire [BW-1:0] factory_bandgap,
	input wire [TW-1:0] factory_term_a,
	input wire [TW-1:0] factory_term_b,
	input wire [TW-1:0] factory_term_c,
	input wire [TW-1:0] factory_term_d,
	input wire swap_start,
	output reg [BW-1:0] bandgap_adjust,
	output wire [TW-1:0] termination_adjust_in_a,
	output wire [TW-1:0] termination_adjust_in_b,
	output wire [TW-1:0] termination_adjust_in_c,
	output wire [TW-1:0] termination_adjust_in_d,
	output reg cal_enable,
	output wire dual_sample,
	output wire steer_select,
	output wire swap_busy
);

	// ****************************************
	// Address decode
	// ****************************************
	function hit;
		input [AW-1:0] addr;
		input [9:0] idx;
		begin
			hit = (addr[AW-1:2] == idx) && (addr[1:0] == 2'b00);
		end
	endfunction

	// ****************************************
	// Declarations
	// ****************************************
	reg loaded_reg;
	reg ack_reg;
	reg [TW-1:0] term_reg [0:3];
	reg [DW-1:0] dual_sample_overlap;
	reg [DW-1:0] steering_select_delay;
	reg [7:0] swap_count_reg;
	reg [31:0] read_next;
	wire req;
	wire wr_commit;
	wire lane0;
	wire [4*TW-1:0] factory_term_all;
	wire swap_done;
	wire swap_go;

	assign factory_term_all = {factory_term_d, factory_term_c,
		factory_term_b, factory_term_a};
	assign termination_adjust_in_a = term_reg[0];
	assign termination_adjust_in_b = term_reg[1];
	assign termination_adjust_in_c = term_reg[2];
	assign termination_adjust_in_d = term_reg[3];

	// ****************************************
	// Bus handshake
	// ****************************************
	assign req = read | write;
	assign waitrequest = !ack_reg;
	assign wr_commit = write && ack_reg;
	assign lane0 = byteenable[0];

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req && loaded_reg && !ack_reg;
		end
	end

	// ****************************************
	// Factory load after reset release
	// ****************************************
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			loaded_reg <= 1'b0;
		end else begin
			loaded_reg <= 1'b1;
		end
	end

	// ****************************************
	// Band-gap trim
	// ****************************************
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bandgap_adjust <= `BANDGAP_RESET;
		end else if (!loaded_reg) begin
			bandgap_adjust <= factory_bandgap;
		end else if (wr_commit && lane0 &&
			hit(address, `IDX_BANDGAP)) begin
			bandgap_adjust <= writedata[BW-1:0];
		end
	end

	// ****************************************
	// Termination trims, one per input
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_term
			localparam [9:0] TERM_IDX = `IDX_TERM_A + i;
			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					term_reg[i] <= `TERM_RESET;
				end else if (!loaded_reg) begin
					term_reg[i] <= factory_term_all[i*TW +: TW];
				end else if (wr_commit && lane0 &&
					hit(address, TERM_IDX)) begin
					term_reg[i] <= writedata[TW-1:0];
				end
			end
		end
	endgenerate

	// ****************************************
	// Swap delay settings and calibration enable
	// ****************************************
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dual_sample_overlap <= `OVERLAP_RESET;
			steering_select_delay <= `STEER_RESET;
			cal_enable <= 1'b0;
		end else if (wr_commit && lane0) begin
			if (hit(address, `IDX_OVERLAP)) begin
				dual_sample_overlap <= writedata[DW-1:0];
			end else if (hit(address, `IDX_STEER)) begin
				steering_select_delay <= writedata[DW-1:0];
			end else if (hit(address, `IDX_SWAP_CTRL)) begin
				cal_enable <= writedata[`CTRL_CAL_EN_BIT];
			end
		end
	end

	// ****************************************
	// Swap sequencing
	// ****************************************
	// Swaps start only with calibration enabled
	assign swap_go = swap_start && cal_enable && !swap_busy;

	swap_timer #(
		.DW(DW),
		.LW(`OVERLAP_LEN_W)
	) u_swap_timer (
		.clk(clk),
		.resetn(resetn),
		.start(swap_go),
		.overlap_set(dual_sample_overlap),
		.steer_delay_set(steering_select_delay),
		.busy(swap_busy),
		.dual_sample(dual_sample),
		.steer_select(steer_select),
		.done(swap_done)
	);

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			swap_count_reg <= 8'h00;
		end else if (swap_done) begin
			swap_count_reg <= swap_count_reg + 8'h01;
		end
	end

	// ****************************************
	// Read mux, reserved bits read as zero
	// ****************************************
	always @* begin
		read_next = 32'h00000000;
		if (hit(address, `IDX_BANDGAP)) begin
			read_next[BW-1:0] = bandgap_adjust;
		end else if (hit(address, `IDX_TERM_A)) begin
			read_next[TW-1:0] = term_reg[0];
		end else if (hit(address, `IDX_TERM_B)) begin
			read_next[TW-1:0] = term_reg[1];
		end else if (hit(address, `IDX_TERM_C)) begin
			read_next[TW-1:0] = term_reg[2];
		end else if (hit(address, `IDX_TERM_D)) begin
			read_next[TW-1:0] = term_reg[3];
		end else if (hit(address, `IDX_OVERLAP)) begin
			read_next[DW-1:0] = dual_sample_overlap;
		end else if (hit(address, `IDX_STEER)) begin
			read_next[DW-1:0] = steering_select_delay;
		end else if (hit(address, `IDX_SWAP_CTRL)) begin
			read_next[`CTRL_CAL_EN_BIT] = cal_enable;
		end else if (hit(address, `IDX_SWAP_STATUS)) begin
			read_next[`STAT_BUSY_BIT] = swap_busy;
			read_next[`STAT_DUAL_BIT] = dual_sample;
			read_next[`STAT_SELECT_BIT] = steer_select;
		end else if (hit(address, `IDX_SWAP_COUNT)) begin
			read_next[7:0] = swap_count_reg;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			readdata <= 32'h00000000;
		end else if (read && loaded_reg && !ack_reg) begin
			readdata <= read_next;
		end
	end

endmodule

// ===== trim_swap_monitor.sv
// Assertions on the trim and swap delay register bank ports
`include "trim_swap_defines.vh"
module trim_swap_monitor (
	input wire clk,
	input wire resetn,
	input wire [11:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	input wire [31:0] readdata,
	input wire waitrequest,
	input wire [3:0] factory_bandgap,
	input wire swap_start,
	input wire [3:0] bandgap_adjust,
	input wire cal_enable,
	input wire dual_sample,
	input wire steer_select,
	input wire swap_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// Shadow state
	// ****************
	logic [4:0] ov_reg, st_reg, ov_lat, st_lat;
	logic [6:0] dual_cnt, sw_cnt;
	wire wr_ok = write && !waitrequest && byteenable[0];
	wire go = swap_start && cal_enable && !swap_busy;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ov_reg <= `OVERLAP_RESET;
			st_reg <= `STEER_RESET;
			ov_lat <= 5'h00;
			st_lat <= 5'h00;
			dual_cnt <= 7'h00;
			sw_cnt <= 7'h7f;
		end else begin
			if (wr_ok && address == {`IDX_OVERLAP, 2'b00})
				ov_reg <= writedata[4:0];
			if (wr_ok && address == {`IDX_STEER, 2'b00})
				st_reg <= writedata[4:0];
			if (go) begin
				ov_lat <= ov_reg;
				st_lat <= st_reg;
			end
			dual_cnt <= dual_sample ? dual_cnt + 7'h01 : 7'h00;
			sw_cnt <= go ? 7'h00 : sw_cnt + {6'h00, sw_cnt != 7'h7f};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence wr_to(logic [9:0] idx);
		wr_ok && address == {idx, 2'b00};
	endsequence
	sequence swap_go;
		go;
	endsequence
	wait_one_cycle_a: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low two cycles");
	bandgap_write_a: assert property (
		wr_to(`IDX_BANDGAP) |=> bandgap_adjust == $past(writedata[3:0]))
		else $error("bandgap write lost");
	factory_load_a: assert property (
		!$past(resetn) |=> bandgap_adjust == $past(factory_bandgap))
		else $error("factory trim not loaded");
	reserved_zero_a: assert property (
		read && !waitrequest && address[11:2] == `IDX_OVERLAP
		|-> readdata[31:5] == 27'h0) else $error("reserved bits set");
	swap_begin_a: assert property (
		swap_go |=> swap_busy && dual_sample) else $error("swap late");
	swap_refused_a: assert property (
		swap_start && !cal_enable && !swap_busy |=> !swap_busy)
		else $error("swap without enable");
	overlap_len_a: assert property (
		$fell(dual_sample) |-> dual_cnt == 7'h04 + {ov_lat, 1'b0})
		else $error("dual sample length wrong");
	steer_time_a: assert property (
		$changed(steer_select) |-> sw_cnt == {2'b00, st_lat} + 7'h01)
		else $error("steer toggle time wrong");
	steer_in_swap_a: assert property (
		$changed(steer_select) |-> $past(swap_busy))
		else $error("steer toggle outside swap");
endmodule
bind trim_and_swap_delay_regs trim_swap_monitor mon (.clk(clk),
	.resetn(resetn), .address(address), .read(read), .write(write),
	.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
	.waitrequest(waitrequest), .factory_bandgap(factory_bandgap),
	.swap_start(swap_start), .bandgap_adjust(bandgap_adjust),
	.cal_enable(cal_enable), .dual_sample(dual_sample),
	.steer_select(steer_select), .swap_busy(swap_busy));

// ===== trim_and_swap_delay_regs_tb_top.sv
// Self-checking bench for the trim and swap delay register bank
`include "trim_swap_defines.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	fails++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module trim_and_swap_delay_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, resetn = 0, read = 0, write = 0, swap_start = 0;
	logic [11:0] address = 12'h000;
	logic [31:0] writedata = 32'h0, rdata, readdata;
	logic [3:0] byteenable = 4'hf, bg;
	logic [3:0] fac_bg = 4'ha;
	logic waitrequest, cal_enable, dual_sample, steer_select, swap_busy;
	logic [7:0] fac[4] = '{8'h11, 8'h22, 8'h33, 8'h44};
	logic [7:0] t_out[4];
	int fails = 0, samples_checked = 0, i;
	always #25 clk = ~clk;
	trim_and_swap_delay_regs uut (.clk(clk), .resetn(resetn),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .factory_bandgap(fac_bg),
		.factory_term_a(fac[0]), .factory_term_b(fac[1]),
		.factory_term_c(fac[2]), .factory_term_d(fac[3]),
		.swap_start(swap_start), .bandgap_adjust(bg),
		.termination_adjust_in_a(t_out[0]), .termination_adjust_in_b(t_out[1]),
		.termination_adjust_in_c(t_out[2]), .termination_adjust_in_d(t_out[3]),
		.cal_enable(cal_enable), .dual_sample(dual_sample),
		.steer_select(steer_select), .swap_busy(swap_busy));
	// ****************
	// Bus and swap tasks
	// ****************
	task automatic wrap_up;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [9:0] idx,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		read <= !w;
		write <= w;
		address <= {idx, 2'b00};
		writedata <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 40);
		rdata = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0) begin
			fails++;
			wrap_up();
		end
	endtask
	task automatic rd(input logic [9:0] idx, input logic [31:0] e,
		input string nm);
		xfer(1'b0, idx, 32'h0);
		`CHK(nm, e, rdata)
	endtask
	task automatic swap(input logic [6:0] e, input logic tog);
		int n, k;
		logic s0;
		s0 = steer_select;
		@(posedge clk);
		swap_start <= 1'b1;
		@(posedge clk);
		swap_start <= 1'b0;
		n = 0;
		for (k = 0; k < 150 && !(k > 2 && swap_busy === 1'b0); k++) begin
			@(posedge clk);
			if (dual_sample === 1'b1)
				n++;
		end
		if (k == 150) begin
			fails++;
			wrap_up();
		end
		`CHK("dual", e, n[6:0])
		`CHK("steer", tog, steer_select !== s0)
	endtask
	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("bg", 4'ha, bg)
		rd(`IDX_BANDGAP, 32'ha, "bg");
		rd(`IDX_OVERLAP, 32'h8, "ovl");
		rd(`IDX_STEER, 32'h7, "steer");
		xfer(1'b1, `IDX_BANDGAP, 32'hf);
		rd(`IDX_BANDGAP, 32'hf, "bg");
		byteenable <= 4'h0;
		xfer(1'b1, `IDX_BANDGAP, 32'h3);
		byteenable <= 4'hf;
		@(posedge clk);
		`CHK("bg", 4'hf, bg)
		for (i = 0; i < 4; i++) begin
			rd(10'(`IDX_TERM_A + i), {24'h0, fac[i]}, "term");
			xfer(1'b1, 10'(`IDX_TERM_A + i), 32'hc0 + i);
			rd(10'(`IDX_TERM_A + i), 32'hc0 + i, "term");
			`CHK("term", 8'(8'hc0 + i), t_out[i])
		end
		rd(10'h07d, 32'h0, "gap");
		xfer(1'b1, `IDX_STEER, 32'h1f);
		rd(`IDX_STEER, 32'h1f, "steer");
		xfer(1'b1, `IDX_OVERLAP, 32'h0);
		xfer(1'b1, `IDX_STEER, 32'h3);
		swap(7'h00, 1'b0);
		xfer(1'b1, `IDX_SWAP_CTRL, 32'h1);
		swap(7'h04, 1'b1);
		for (i = 7; i < 32; i += 24) begin
			xfer(1'b1, `IDX_SWAP_CTRL, 32'h0);
			xfer(1'b1, `IDX_OVERLAP, i);
			xfer(1'b1, `IDX_STEER, i);
			xfer(1'b1, `IDX_SWAP_CTRL, 32'h1);
			swap(7'(4 + 2 * i), 1'b1);
		end
		// Steering delay written mid-swap must wait for the next swap
		fork
			swap(7'h42, 1'b1);
			begin
				repeat (3) @(posedge clk);
				xfer(1'b1, `IDX_STEER, 32'h2);
			end
		join
		swap(7'h42, 1'b1);
		// Steering delay beyond the window stretches the swap
		xfer(1'b1, `IDX_SWAP_CTRL, 32'h0);
		xfer(1'b1, `IDX_OVERLAP, 32'h0);
		xfer(1'b1, `IDX_STEER, 32'h1f);
		xfer(1'b1, `IDX_SWAP_CTRL, 32'h1);
		swap(7'h04, 1'b1);
		rd(`IDX_SWAP_CTRL, 32'h1, "ctrl");
		`CHK("cal", 1'b1, cal_enable)
		rd(`IDX_SWAP_COUNT, 32'h6, "count");
		wrap_up();
	end
endmodule
